// ### pkg/sadc_pkg.sv
// Constants and types for the converter's conversion and serial port logic
package sadc_pkg;

  //--------------------------------------------------------------------------
  // Widths and timing
  //--------------------------------------------------------------------------
  localparam int          RES_BITS       = 16;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam real         CONV_HI_US     = 2.2;
  localparam real         CONV_LO_US     = 3.2;
  localparam int          CONV_HI_CYC    = int'(CONV_HI_US * 1000.0)
                                           / CLK_PERIOD_NS;
  localparam int          CONV_LO_CYC    = int'(CONV_LO_US * 1000.0)
                                           / CLK_PERIOD_NS;
  // Converter finishes well inside the shorter limit
  localparam logic [8:0]  CONV_CYC       = 9'(CONV_HI_CYC - 20);
  localparam logic [4:0]  BIT_CNT_RST    = 5'h00;
  localparam logic [15:0] CFG_RST        = 16'h0000;
  localparam int          FIFO_DEPTH     = 8;

  //--------------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------------
  typedef struct packed {
    logic conv_start;
    logic sclk;
    logic cfg_bit;
  } sadc_pins_t;

  typedef struct packed {
    logic bipolar;
    logic [15:0] code;
  } sadc_sample_t;

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_READY} sadc_state_t;

endpackage : sadc_pkg

// ### core/sadc_fifo.sv
// Small parameterised FIFO holding samples ahead of conversion
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // Handshakes
  assign push = in_valid_in && (cnt_ff != (AW+1)'(DEPTH));
  assign pop  = out_valid_out && out_ready_in;

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read side: data held in a flop ahead of consumer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      in_ready_out  <= 1'b0;
    end else begin
      in_ready_out <= (cnt_ff + (AW+1)'(push)) < (AW+1)'(DEPTH);
      out_valid_out <= (cnt_ff - (AW+1)'(pop) + (AW+1)'(push)) != '0;
      out_data_out  <= mem_ff[pop ? rd_ff + 1'b1 : rd_ff];
      if (cnt_ff == '0 || (pop && cnt_ff == (AW+1)'(1))) begin
        out_data_out <= in_data_in;
      end
    end
  end

endmodule : sadc_fifo

// ### core/sadc_core.sv
// Conversion sequencing and serial result/configuration port
`timescale 1ns/1ps
module sadc_core (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire sadc_pkg::sadc_pins_t  pins_in,
  input  wire sadc_pkg::sadc_sample_t sample_in,
  input  wire logic                  sample_valid_in,
  output logic                       sample_ready_out,
  output logic                       result_out,
  output logic                       result_oe_out,
  output logic                       busy_out,
  output logic [15:0]                cfg_word_out
);

  //--------------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------------
  sadc_pkg::sadc_pins_t meta_ff;
  sadc_pkg::sadc_pins_t sync_ff;
  sadc_pkg::sadc_pins_t prev_ff;

  // Two flops before any logic reads a pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge detect on synchronised levels, shared by both pins
  function automatic logic edge_up(input logic now_lvl,
                                   input logic was_lvl);
    return now_lvl && !was_lvl;
  endfunction : edge_up

  function automatic logic edge_down(input logic now_lvl,
                                     input logic was_lvl);
    return !now_lvl && was_lvl;
  endfunction : edge_down

  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_rise   = edge_up(sync_ff.conv_start, prev_ff.conv_start);
  assign cs_fall   = edge_down(sync_ff.conv_start, prev_ff.conv_start);
  assign sclk_rise = edge_up(sync_ff.sclk, prev_ff.sclk);
  assign sclk_fall = edge_down(sync_ff.sclk, prev_ff.sclk);

  //--------------------------------------------------------------------------
  // Sample source FIFO
  //--------------------------------------------------------------------------
  logic                  fifo_valid;
  logic                  fifo_take;
  sadc_pkg::sadc_sample_t fifo_data;

  sadc_fifo #(
    .WIDTH ($bits(sadc_pkg::sadc_sample_t)),
    .DEPTH (sadc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (sample_valid_in),
    .in_ready_out  (sample_ready_out),
    .in_data_in    (sample_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_take),
    .out_data_out  (fifo_data)
  );

  //--------------------------------------------------------------------------
  // Conversion state
  //--------------------------------------------------------------------------
  sadc_pkg::sadc_state_t state_ff;
  logic [8:0]            conv_cnt_ff;
  logic [15:0]           result_ff;

  // Sample is consumed when conversion finishes; stalls if FIFO empty
  assign fifo_take = (state_ff == sadc_pkg::S_CONV) && (conv_cnt_ff == '0)
                     && fifo_valid;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff    <= sadc_pkg::S_IDLE;
      conv_cnt_ff <= '0;
    end else begin
      case (state_ff)
        sadc_pkg::S_IDLE, sadc_pkg::S_READY: begin
          if (cs_rise) begin
            state_ff    <= sadc_pkg::S_CONV;
            conv_cnt_ff <= sadc_pkg::CONV_CYC;
          end
        end
        sadc_pkg::S_CONV: begin
          if (conv_cnt_ff != '0) begin
            conv_cnt_ff <= conv_cnt_ff - 9'h001;
          end else if (fifo_take) begin
            state_ff <= sadc_pkg::S_READY;
          end
        end
        default: begin
          state_ff <= sadc_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Code format: offset binary flipped to two's complement when bipolar
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_ff <= '0;
    end else if (fifo_take) begin
      result_ff <= fifo_data.bipolar ? {~fifo_data.code[15],
                   fifo_data.code[14:0]} : fifo_data.code;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_ff == sadc_pkg::S_CONV) || cs_rise;
    end
  end

  //--------------------------------------------------------------------------
  // Serial shifter
  //--------------------------------------------------------------------------
  logic [15:0] shift_ff;
  logic [4:0]  bit_cnt_ff;
  logic [15:0] cfg_shift_ff;

  // True on the count that marks the final bit of a frame
  function automatic logic last_bit(input logic [4:0] cnt);
    return cnt == 5'(sadc_pkg::RES_BITS - 1);
  endfunction : last_bit

  // Load latest result on start-low, shift on clock falls
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_ff      <= '0;
      bit_cnt_ff    <= sadc_pkg::BIT_CNT_RST;
      result_oe_out <= 1'b0;
      result_out    <= 1'b0;
    end else if (sync_ff.conv_start) begin
      result_oe_out <= 1'b0;
      bit_cnt_ff    <= sadc_pkg::BIT_CNT_RST;
    end else if (cs_fall) begin
      shift_ff      <= {result_ff[14:0], 1'b0};
      result_out    <= result_ff[15];
      result_oe_out <= 1'b1;
      bit_cnt_ff    <= sadc_pkg::BIT_CNT_RST;
    end else if (sclk_fall && result_oe_out) begin
      result_out <= shift_ff[15];
      shift_ff   <= {shift_ff[14:0], 1'b0};
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (last_bit(bit_cnt_ff)) begin
        result_oe_out <= 1'b0;
      end
    end
  end

  // Configuration capture on rising clock edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_shift_ff <= sadc_pkg::CFG_RST;
      cfg_word_out <= sadc_pkg::CFG_RST;
    end else if (sclk_rise && !sync_ff.conv_start) begin
      cfg_shift_ff <= {cfg_shift_ff[14:0], sync_ff.cfg_bit};
      if (last_bit(bit_cnt_ff)) begin
        cfg_word_out <= {cfg_shift_ff[14:0], sync_ff.cfg_bit};
      end
    end
  end

  //--------------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Slower supply limit bounds the check; fixed conversion meets both
  localparam int CONV_LIM_CYC = sadc_pkg::CONV_LO_CYC;

  sequence start_low_s;
    cs_fall;
  endsequence

  sequence last_fall_s;
    sclk_fall && result_oe_out && !sync_ff.conv_start
    && last_bit(bit_cnt_ff);
  endsequence

  sequence cfg_last_rise_s;
    sclk_rise && !sync_ff.conv_start && last_bit(bit_cnt_ff);
  endsequence

  conv_done_a: assert property (
    cs_rise && fifo_valid |-> ##[1:CONV_LIM_CYC]
    (state_ff == sadc_pkg::S_READY))
    else $error("conversion not done in time");
  busy_conv_a: assert property ((state_ff == sadc_pkg::S_CONV)
    |=> busy_out)
    else $error("busy low during conversion");
  last_fall_a: assert property (last_fall_s
    |=> !result_oe_out)
    else $error("output not released after last fall");
  cfg_word_a: assert property (cfg_last_rise_s
    |=> cfg_word_out == cfg_shift_ff)
    else $error("config word not latched");
  top_bit_a: assert property (start_low_s |=> result_oe_out
    && result_out == $past(result_ff[15]))
    else $error("top bit not presented");
  shift_fall_a: assert property (sclk_fall && result_oe_out
    && !sync_ff.conv_start |=> result_out == $past(shift_ff[15]))
    else $error("output did not advance on fall");
  release_hi_a: assert property (sync_ff.conv_start
    |=> !result_oe_out)
    else $error("output not released");
  hold_rise_a: assert property ($changed(result_out)
    |-> $past(sclk_fall) || $past(cs_fall))
    else $error("output changed off a fall");
  cfg_cap_a: assert property (sclk_rise && !sync_ff.conv_start
    |=> cfg_shift_ff[0] == $past(sync_ff.cfg_bit))
    else $error("config bit not captured");
  fmt_a: assert property (fifo_take && !fifo_data.bipolar
    |=> result_ff == $past(fifo_data.code))
    else $error("unipolar code altered");
  no_pipe_a: assert property (fifo_take
    |=> state_ff == sadc_pkg::S_READY)
    else $error("result not ready after conversion");

endmodule : sadc_core

// ### testbench/sadc_host_model.sv
// Host model: conversion start, serial clock and config bits
`timescale 1ns/1ps
module sadc_host_model (
  input  wire logic           clk_in,
  input  wire logic           result_in,
  input  wire logic           result_oe_in,
  output sadc_pkg::sadc_pins_t pins_out
);
  logic oe_ok;
  initial begin
    pins_out = '0;
    oe_ok = 1'b1;
  end
  // Rise of conversion start; also closes a frame
  task automatic start_conv();
    @(posedge clk_in);
    pins_out.conv_start <= 1'b1;
  endtask : start_conv
  // Serial clock idles low between frames, 80 ns period inside
  task automatic read_frame(input logic [15:0] cfg, input int npulse,
                            output logic [15:0] data);
    data = '0;
    @(posedge clk_in);
    pins_out.conv_start <= 1'b0;
    pins_out.cfg_bit    <= cfg[15];
    repeat (8) @(posedge clk_in);
    for (int k = 0; k < npulse; k++) begin
      pins_out.sclk <= 1'b1;
      #1;
      // A released output reads as garbage, not as the last bit
      data  = {data[14:0], result_oe_in ? result_in : ~result_in};
      oe_ok &= result_oe_in;
      repeat (4) @(posedge clk_in);
      pins_out.sclk <= 1'b0;
      // Config bit moves on the fall, far from the capturing rise
      pins_out.cfg_bit <= (k < 15) ? cfg[14-k] : ~cfg[0];
      repeat (4) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
    pins_out.conv_start <= 1'b1;
  endtask : read_frame
endmodule : sadc_host_model

// ### testbench/tb_top.sv
// Self-checking bench for conversion and serial result port
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    sadc_pkg::sadc_sample_t smp;
    logic [15:0]            cfg;
    logic [15:0]            exp_res;
  } sadc_row_t;
  logic                   clk_in;
  logic                   rst_in;
  logic                   sample_valid_in;
  logic                   sample_ready_out;
  logic                   result_out;
  logic                   result_oe_out;
  logic                   busy_out;
  logic [15:0]            cfg_word_out;
  logic [15:0]            rd;
  sadc_pkg::sadc_pins_t   pins_in;
  sadc_pkg::sadc_sample_t sample_in;
  int                     mismatches;
  int                     check_count;
  int                     n;
  // Bipolar codes arrive offset binary, leave two's complement
  sadc_row_t rows [8] = '{
    {1'b0, 16'h0000, 16'h1234, 16'h0000},
    {1'b0, 16'hffff, 16'h8001, 16'hffff},
    {1'b1, 16'h8000, 16'hffff, 16'h0000},
    {1'b1, 16'h7fff, 16'h0000, 16'hffff},
    {1'b1, 16'h0000, 16'ha5a5, 16'h8000},
    {1'b1, 16'hffff, 16'h5a5a, 16'h7fff},
    {1'b0, 16'ha5a5, 16'h0f0f, 16'ha5a5},
    {1'b0, 16'h5a5a, 16'hf0f0, 16'h5a5a}};

  sadc_core DUT (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .pins_in          (pins_in),
    .sample_in        (sample_in),
    .sample_valid_in  (sample_valid_in),
    .sample_ready_out (sample_ready_out),
    .result_out       (result_out),
    .result_oe_out    (result_oe_out),
    .busy_out         (busy_out),
    .cfg_word_out     (cfg_word_out)
  );
  sadc_host_model host (
    .clk_in       (clk_in),
    .result_in    (result_out),
    .result_oe_in (result_oe_out),
    .pins_out     (pins_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Hold valid until an edge samples ready high; bounded
  task automatic push_wait();
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (sample_ready_out !== 1'b1 && n < 50);
    check(n < 50, 1'b1);
    if (n >= 50) print_verdict();
  endtask : push_wait

  // Busy must drop within the limit counted from the start edge
  task automatic wait_conv(input int limit);
    n = 0;
    while (n < limit && !(n > 8 && busy_out === 1'b0)) begin
      @(posedge clk_in);
      n++;
      if (n == 8) begin
        check(busy_out, 1'b1);
      end
    end
    check(n < limit, 1'b1);
    if (n >= limit) print_verdict();
  endtask : wait_conv

  initial begin
    rst_in          = 1'b1;
    sample_valid_in = 1'b0;
    sample_in       = '0;
    mismatches      = 0;
    check_count     = 0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check(busy_out, 1'b0);
    check(result_oe_out, 1'b0);
    check(cfg_word_out, 16'h0000);
    $display("test reset done");
    // Fill the queue until it refuses
    sample_valid_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sample_in <= rows[i].smp;
      push_wait();
    end
    sample_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(sample_ready_out, 1'b0);
    $display("test fill done");
    host.start_conv();
    for (int i = 0; i < 8; i++) begin
      wait_conv(221);
      if (i == 0) begin
        sample_valid_in <= 1'b1;
        sample_in       <= rows[3].smp;
        push_wait();
        sample_valid_in <= 1'b0;
      end
      // Transfer only once the result is ready
      host.read_frame(rows[i].cfg, 16, rd);
      check(rd, rows[i].exp_res);
      check(result_oe_out, 1'b0);
      check(host.oe_ok, 1'b1);
      check(cfg_word_out, rows[i].cfg);
      $display("test row %0d done", i);
    end
    // Frame cut short after five clocks by raising start
    wait_conv(221);
    host.read_frame(16'h0000, 5, rd);
    check(rd, 16'h001f);
    check(result_oe_out, 1'b1);
    repeat (6) @(posedge clk_in);
    check(result_oe_out, 1'b0);
    check(cfg_word_out, rows[7].cfg);
    $display("test abort done");
    print_verdict();
  end
endmodule : tb_top
